// >>> link_frame_consts.svh
/*
  Constants for the serial control frame interface: register offsets,
  field positions, shift-register taps and timing figures.
  Assumes it is included by its bare name wherever these names are used.
*/
`ifndef LINK_FRAME_CONSTS_SVH
`define LINK_FRAME_CONSTS_SVH

// register byte offsets
`define CTRL_OFS        8'h80
`define STATUS_OFS      8'h84
`define RX_DATA_OFS     8'h88
`define TX_DATA_OFS     8'h8c

// control register fields
`define CTRL_EXT_STB_D  0
`define CTRL_TX_CLR     1
`define CTRL_SIS_SET    3
`define CTRL_PAR_SEL    6
`define CTRL_RST        8'h00

// status register fields
`define STAT_RX_PEND    0
`define STAT_TX_PEND    1
`define STAT_SIS        2
`define STAT_INHIBIT    7

// sync detector taps and byte counter terminal value
`define SD_RESET_TAP    2
`define SD_OUT_TAP      3
`define BYTE_LAST       3'h7

// receive strobe width and system clock rate
`define STROBE_NS       5000
`define CLK_KHZ         20000

// axi response codes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> link_frame_pkg.sv
/*
  Types shared by the serial control frame interface.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package link_frame_pkg;

    // pending lines toward the parallel io device
    typedef struct packed {
        logic tx;
        logic rx;
    } pend_s;

    // edges of the link bit clock seen on aclk
    typedef struct packed {
        logic rise;
        logic fall;
    } link_edge_s;

endpackage : link_frame_pkg

// >>> serial_control_frame_interface.sv
/*
  Serial control frame interface: receive sync detector, byte strobe and
  latch, transmit load timing and shift register, AXI4-Lite register slave.
  Assumes a free-running aclk far faster than the link bit clock, which
  arrives as an ordinary pin and is edge-detected after synchronisation.
*/
`timescale 1ns/1ps
`default_nettype none
`include "link_frame_consts.svh"

module serial_control_frame_interface #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // axi4-lite write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // link pins
    input  wire logic                link_clk,
    input  wire logic                link_din_n,
    input  wire logic                ext_rev_din,
    input  wire logic                cmp_inhibit,
    output logic                     ext_dout,
    output logic                     tx_dout,
    output logic                     ext_strobe,
    // pending lines toward the parallel io device
    output link_frame_pkg::pend_s    pend
);
    import link_frame_pkg::*;

    localparam int STROBE_CYC = (`STROBE_NS * `CLK_KHZ + 999999) / 1000000;

    // elaboration check: map needs 8 address bits, strobe counter is 8 bits
    if (ADDR_W < 8 || STROBE_CYC > 255 || STROBE_CYC < 1) begin : g_bad_param
        $error("serial_control_frame_interface: unsupported parameter");
    end

    logic [3:0]  sync1_ff;
    logic [3:0]  sync2_ff;
    logic        clk_d_ff;
    link_edge_s  edge_e;
    logic        din_s;
    logic        ext_s;
    logic [3:0]  sd_a_ff;
    logic [3:0]  sd_b_ff;
    logic [3:0]  nxt_sd_a;
    logic [3:0]  sd_b_shift;
    logic        detect;
    logic [2:0]  rx_cnt_ff;
    logic        rx_term;
    logic        strobe_go;
    logic [7:0]  strobe_cnt_ff;
    logic [7:0]  rx_sh_ff;
    logic [7:0]  nxt_rx_sh;
    logic [7:0]  rx_byte_ff;
    logic        ext_dout_ff;
    logic        rx_pend_ff;
    logic        tx_pend_ff;
    logic        sis_ff;
    logic        load_ff;
    logic        load_go;
    logic        tx_run_ff;
    logic [2:0]  tx_cnt_ff;
    logic        tx_term;
    logic        par_sel_ff;
    logic [7:0]  tx_sh_ff;
    logic        tx_dout_ff;
    logic        ext_strobe_ff;
    logic [7:0]  ctrl_ff;
    logic [7:0]  tx_data_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        do_write;
    logic        do_read;
    logic        wr_ctrl;
    logic        rd_rx;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `CTRL_OFS) || (a == `STATUS_OFS) || (a == `RX_DATA_OFS) || (a == `TX_DATA_OFS);
    endfunction : is_mapped

    // two flops on every pin before use: clock, data, revertive, inhibit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            clk_d_ff <= 1'b0;
        end else begin
            sync1_ff <= {cmp_inhibit, ext_rev_din, link_din_n, link_clk};
            sync2_ff <= sync1_ff;
            clk_d_ff <= sync2_ff[0];
        end
    end

    assign edge_e.rise = sync2_ff[0] & ~clk_d_ff;
    assign edge_e.fall = ~sync2_ff[0] & clk_d_ff;
    assign din_s       = sync2_ff[1];
    assign ext_s       = sync2_ff[2];

    // sync detector: second stage cleared while the first holds a one at its
    // reset tap, and still during the edge on which the tap drops
    always_comb begin
        nxt_sd_a   = {sd_a_ff[2:0], din_s};
        sd_b_shift = sd_a_ff[`SD_RESET_TAP] ? 4'h0 : {sd_b_ff[2:0], 1'b1};
    end

    // output rises only on the third edge after a one and four zeros; later bits are ignored
    assign detect = edge_e.rise & sd_b_shift[`SD_OUT_TAP] & ~sd_b_ff[`SD_OUT_TAP];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sd_a_ff <= 4'h0;
            sd_b_ff <= 4'h0;
        end else if (edge_e.rise) begin
            sd_a_ff <= nxt_sd_a;
            sd_b_ff <= nxt_sd_a[`SD_RESET_TAP] ? 4'h0 : sd_b_shift;
        end
    end

    // receive byte counter, restarted by the sync detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt_ff <= 3'h0;
        end else if (detect) begin
            rx_cnt_ff <= 3'h0;
        end else if (edge_e.rise) begin
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
        end
    end

    assign rx_term   = edge_e.rise & ~detect & (rx_cnt_ff == `BYTE_LAST);
    assign strobe_go = detect | rx_term;

    // strobe pulse: fixed width, retriggered only from idle like the one-shot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_cnt_ff <= 8'h00;
        end else if (strobe_go && strobe_cnt_ff == 8'h00) begin
            strobe_cnt_ff <= 8'(STROBE_CYC);
        end else if (strobe_cnt_ff != 8'h00) begin
            strobe_cnt_ff <= strobe_cnt_ff - 8'h01;
        end
    end

    // input shift register: first frame bit ends in bit 0 of the byte
    assign nxt_rx_sh = {~din_s, rx_sh_ff[7:1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sh_ff    <= 8'h00;
            ext_dout_ff <= 1'b0;
        end else if (edge_e.rise) begin
            rx_sh_ff    <= nxt_rx_sh;
            ext_dout_ff <= ~rx_sh_ff[0];
        end
    end

    // byte latch loaded by every strobe; an unread byte is overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_byte_ff <= 8'h00;
        end else if (strobe_go) begin
            rx_byte_ff <= nxt_rx_sh;
        end
    end

    // receive pending latch: a strobe in the read cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pend_ff <= 1'b0;
        end else if (strobe_go) begin
            rx_pend_ff <= 1'b1;
        end else if (rd_rx) begin
            rx_pend_ff <= 1'b0;
        end
    end

    // start-in-sync latch: set by software, spent by the aligned load
    assign load_go = (sis_ff & rx_term) | (tx_run_ff & ~sis_ff & tx_term);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sis_ff <= 1'b0;
        end else if (sis_ff & rx_term) begin
            sis_ff <= 1'b0;
        end else if (wr_ctrl && wdata_ff[`CTRL_SIS_SET]) begin
            sis_ff <= 1'b1;
        end
    end

    // load pulse: from a rising edge to the following falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_ff <= 1'b0;
        end else if (load_go) begin
            load_ff <= 1'b1;
        end else if (edge_e.fall) begin
            load_ff <= 1'b0;
        end
    end

    // transmit counter held while armed or loading, so it restarts in step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_run_ff <= 1'b0;
            tx_cnt_ff <= 3'h0;
        end else begin
            if (sis_ff & rx_term) begin
                tx_run_ff <= 1'b1;
            end
            if (sis_ff || load_ff || !tx_run_ff) begin
                tx_cnt_ff <= 3'h0;
            end else if (edge_e.rise) begin
                tx_cnt_ff <= tx_cnt_ff + 3'h1;
            end
        end
    end

    assign tx_term = edge_e.rise & tx_run_ff & ~sis_ff & ~load_ff & (tx_cnt_ff == `BYTE_LAST);

    // transmit pending set at the trailing edge of the load pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend_ff <= 1'b0;
        end else if (load_ff && edge_e.fall) begin
            tx_pend_ff <= 1'b1;
        end else if (wr_ctrl && wdata_ff[`CTRL_TX_CLR]) begin
            tx_pend_ff <= 1'b0;
        end
    end

    // load source latch and output shift register; shifts on falling edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            par_sel_ff <= 1'b0;
            tx_sh_ff   <= 8'h00;
            tx_dout_ff <= 1'b0;
        end else if (load_go) begin
            par_sel_ff <= ctrl_ff[`CTRL_PAR_SEL];
            if (ctrl_ff[`CTRL_PAR_SEL]) begin
                tx_sh_ff <= tx_data_ff;
            end
        end else if (edge_e.fall) begin
            // the fall that ends a load shifts too, or one bit per byte is lost
            // serial mode passes revertive data behind the host's sync byte
            tx_sh_ff   <= {par_sel_ff ? 1'b0 : ext_s, tx_sh_ff[7:1]};
            tx_dout_ff <= tx_sh_ff[0];
        end
    end

    // external strobe flop clocked by the transmit terminal count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_strobe_ff <= 1'b0;
        end else if (tx_term) begin
            ext_strobe_ff <= ctrl_ff[`CTRL_EXT_STB_D];
        end
    end

    // axi write: address and data taken in either order, answer after both
    assign awready  = ~aw_held_ff & ~bvalid_ff;
    assign wready   = ~w_held_ff & ~bvalid_ff;
    assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign wr_ctrl  = do_write & (awaddr_ff == `CTRL_OFS) & wstrb_ff[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= awaddr[7:0];
            end
            if (wvalid && wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= is_mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // writable registers; the pulse bits of control never store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff    <= `CTRL_RST;
            tx_data_ff <= 8'h00;
        end else if (do_write && wstrb_ff[0]) begin
            if (awaddr_ff == `CTRL_OFS) begin
                ctrl_ff <= wdata_ff[7:0] & ~(8'h01 << `CTRL_TX_CLR) & ~(8'h01 << `CTRL_SIS_SET);
            end
            if (awaddr_ff == `TX_DATA_OFS) begin
                tx_data_ff <= wdata_ff[7:0];
            end
        end
    end

    // axi read: one-cycle answer; the byte is driven only by a data read
    assign arready = ~rvalid_ff;
    assign do_read = arvalid & arready;
    assign rd_rx   = do_read & (araddr[7:0] == `RX_DATA_OFS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `RESP_OKAY;
        end else if (do_read) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= is_mapped(araddr[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
            case (araddr[7:0])
                `CTRL_OFS:    rdata_ff <= {24'h00_0000, ctrl_ff};
                `STATUS_OFS:  rdata_ff <= {24'h00_0000, sync2_ff[3], 4'h0, sis_ff, tx_pend_ff, rx_pend_ff};
                `RX_DATA_OFS: rdata_ff <= {24'h00_0000, rx_byte_ff};
                `TX_DATA_OFS: rdata_ff <= {24'h00_0000, tx_data_ff};
                default:      rdata_ff <= 32'h0000_0000;
            endcase
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
        end
    end

    // outputs
    assign bvalid     = bvalid_ff;
    assign bresp      = bresp_ff;
    assign rvalid     = rvalid_ff;
    assign rdata      = rdata_ff;
    assign rresp      = rresp_ff;
    assign ext_dout   = ext_dout_ff;
    assign tx_dout    = tx_dout_ff;
    assign ext_strobe = ext_strobe_ff;
    assign pend.rx    = rx_pend_ff;
    assign pend.tx    = tx_pend_ff;

    // helper counters for the checks below
    logic [7:0] strobe_w_ff;
    logic [3:0] rises_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_w_ff <= 8'h00;
            rises_ff    <= 4'h0;
        end else begin
            strobe_w_ff <= (strobe_cnt_ff != 8'h00) ? strobe_w_ff + 8'h01 : 8'h00;
            rises_ff    <= strobe_go ? 4'h0 : (edge_e.rise ? rises_ff + 4'h1 : rises_ff);
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence aligned_load_s;
        sis_ff && rx_term;
    endsequence
    sequence load_end_s;
        load_ff && edge_e.fall;
    endsequence

    sync_code_a: assert property (detect |=> rx_byte_ff[4:0] == 5'h1e)
        else $error("sync strobe without inverted sync pattern");
    strobe_width_a: assert property ($fell(strobe_cnt_ff != 8'h00) |-> strobe_w_ff == 8'(STROBE_CYC))
        else $error("receive strobe width wrong");
    rx_term_gap_a: assert property (rx_term |-> rises_ff == 4'h7)
        else $error("receive terminal not eight clocks after strobe");
    rx_pend_set_a: assert property (strobe_go |=> pend.rx && rx_byte_ff == $past(nxt_rx_sh))
        else $error("strobe did not latch byte and set pending");
    rx_read_clr_a: assert property (rd_rx && !strobe_go |=> !pend.rx && rdata == {24'h0, $past(rx_byte_ff)})
        else $error("receive read did not clear pending or return byte");
    load_align_a: assert property (aligned_load_s |=> load_ff && !sis_ff && tx_run_ff)
        else $error("start-in-sync did not produce aligned load");
    load_half_a: assert property (load_end_s |=> !load_ff && pend.tx)
        else $error("load pulse did not end on falling edge");
    par_load_a: assert property (load_go && ctrl_ff[`CTRL_PAR_SEL] |=> tx_sh_ff == $past(tx_data_ff))
        else $error("parallel byte not loaded");
    ext_strobe_a: assert property (tx_term |=> ext_strobe == $past(ctrl_ff[`CTRL_EXT_STB_D]))
        else $error("external strobe not taken at terminal count");

endmodule : serial_control_frame_interface
`default_nettype wire

// >>> link_far_end.sv
/*
  Far-side link model: bit clock, inverted serial data, revertive data.
  Assumes the bench calls send_frame; the clock stands still between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module link_far_end (
    // link pins toward the block
    output var logic link_clk,
    output var logic link_din_n,
    output var logic ext_rev_din
);
    // idle: clock low, data at the pulled-up level
    initial begin
        link_clk    = 1'b0;
        link_din_n  = 1'b1;
        ext_rev_din = 1'b1;
    end

    // one 48-bit frame, bit 0 first; forward data moves with the falling
    // edge, revertive data with the rising one so it stands at the fall
    task automatic send_frame(input logic [47:0] pin, input logic [39:0] rev);
        #7;
        for (int i = 0; i < 48; i++) begin
            link_din_n = pin[i];
            #200 link_clk = 1'b1;
            if (i >= 8) ext_rev_din = rev[i-8];
            #200 link_clk = 1'b0;
        end
        link_din_n  = 1'b1;         // released line goes to pull-up
        ext_rev_din = ~ext_rev_din; // stale value must not linger
    endtask : send_frame
endmodule : link_far_end
`default_nettype wire

// >>> serial_control_frame_interface_bench.sv
/*
  Self-checking bench: register access, receive frames, transmit timing.
  Assumes the block, its package and constants header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "link_frame_consts.svh"
module serial_control_frame_interface_bench;
    import link_frame_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, cmp_inhibit = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        link_clk, link_din_n, ext_rev_din, ext_dout, tx_dout, ext_strobe;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    pend_s       pend;
    int          n_mismatch = 0;
    int          check_count = 0;

    // 20 MHz system clock
    always #25 aclk = ~aclk;

    serial_control_frame_interface #(.ADDR_W(8)) dut_u (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .link_din_n,
        .ext_rev_din, .cmp_inhibit, .ext_dout, .tx_dout, .ext_strobe, .pend
    );

    link_far_end far_u (.link_clk, .link_din_n, .ext_rev_din);

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task complete_run;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // handshakes judged between edges, where valid and ready are settled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ta, tw, tb;
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge aclk); // no re-raise in the same step
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ta, tr;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r,
                          input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(d, exp, what);
        check({30'h0, r}, {30'h0, exp_r}, what);
    endtask : rd_chk

    // host reads every byte of a frame while the far end sends it
    task automatic rx_frame(input logic [47:0] fr, input logic [39:0] rev, input logic [31:0] st0);
        fork
            far_u.send_frame(fr, rev);
            for (int i = 0; i < 6; i++) begin
                for (int n = 0; n < 400 && pend.rx !== 1'b1; n++) @(negedge aclk);
                check(pend.rx, 1'b1, "rx pending");
                if (i > 0) check(ext_dout, fr[i*8-1], "ext data out");
                @(posedge aclk);
                rd_chk(`RX_DATA_OFS, {24'h0, ~fr[i*8 +: 8]}, `RESP_OKAY, "rx byte");
                @(negedge aclk);
                check(rdata, 32'h0, "rdata idle");
                @(posedge aclk);
                if (i == 0) rd_chk(`STATUS_OFS, st0, `RESP_OKAY, "rx cleared");
            end
        join
    endtask : rx_frame

    task automatic test_regs;
        logic [1:0] r;
        check(pend, 2'b00, "pend reset");
        axi_wr(`CTRL_OFS, 32'h02, r);
        rd_chk(`RX_DATA_OFS, 32'h0, `RESP_OKAY, "rx data reset");
        rd_chk(`STATUS_OFS, 32'h0, `RESP_OKAY, "status idle");
        cmp_inhibit <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(`STATUS_OFS, 32'h80, `RESP_OKAY, "status inhibit");
        cmp_inhibit <= 1'b0;
        rd_chk(8'h90, 32'h0, `RESP_SLVERR, "unmapped read");
        axi_wr(8'h90, 32'hff, r);
        check(r, `RESP_SLVERR, "unmapped write");
        rd_chk(`CTRL_OFS, `CTRL_RST, `RESP_OKAY, "ctrl reset");
    endtask : test_regs

    task automatic test_rx;
        rx_frame(48'hb55a5a5a5a61, 40'h0, 32'h0);
        check(ext_dout, 1'b0, "ext data out");
    endtask : test_rx

    // parallel source armed before the frame; sync carries other don't-cares
    task automatic test_tx;
        logic [1:0] r;
        axi_wr(`TX_DATA_OFS, 32'ha5, r);
        axi_wr(`CTRL_OFS, 32'h49, r);
        rd_chk(`CTRL_OFS, 32'h41, `RESP_OKAY, "ctrl readback");
        rd_chk(`STATUS_OFS, 32'h04, `RESP_OKAY, "sis armed");
        rx_frame(48'hb55a5a5a5a21, 40'h123456789a, 32'h04);
        check(tx_dout, 1'b1, "parallel tx data");
        check(pend.tx, 1'b1, "tx pending");
        check(ext_strobe, 1'b1, "ext strobe");
        axi_wr(`CTRL_OFS, 32'h43, r);
        rd_chk(`STATUS_OFS, 32'h0, `RESP_OKAY, "tx cleared");
    endtask : test_tx

    // serial source: revertive bits leave eight falls after they arrive
    task automatic test_serial;
        logic [1:0] r;
        axi_wr(`CTRL_OFS, 32'h08, r);
        rx_frame(48'hb55a5a5a5a61, 40'h5ac3a50f96, 32'h04);
        check(tx_dout, 1'b1, "serial tx data");
        check(ext_strobe, 1'b0, "ext strobe low");
        check(pend.tx, 1'b1, "tx pending serial");
    endtask : test_serial

    // main sequence: reset held ten cycles
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_regs();
        test_rx();
        test_tx();
        test_serial();
        complete_run();
    end

    // watchdog well beyond three frames of 48 link bits
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : serial_control_frame_interface_bench
`default_nettype wire
